// ===== logic/scan_cfg_defs.vh
// register offsets, field positions, reset values and state codes for the scan configuration
`ifndef SCAN_CFG_DEFS_VH
`define SCAN_CFG_DEFS_VH
`define ADDR_SCAN_CONTROL      3'h4
`define ADDR_CHANNEL_MAP_HIGH  3'h5
`define ADDR_CHANNEL_MAP_LOW   3'h6
`define SCAN_CONTROL_RESET     16'h0001
`define CHANNEL_MAP_RESET      24'h000000
`define SEL_MSB                15
`define SEL_LSB                13
`define MODE_MSB               12
`define MODE_LSB               11
`define OUT_DLY_EN_BIT         10
`define CH_DLY_EN_BIT          9
`define RDY_INH_BIT            8
`define SPEED_MSB              1
`define SPEED_LSB              0
`define SCAN_CONTROL_WMASK     16'hff03
`define LAST_CHANNEL           3'h5
`define FIRST_POSITION         3'h1
`define LAST_POSITION          3'h6
`define MODE_SINGLE            2'h0
`define MODE_INHIBIT_OK        2'h1
`define CH_FIELD_W             8
`define MAP_MSB                7
`define MAP_LSB                5
`define POS_MSB                4
`define POS_LSB                2
`define EN_BIT                 1
`define OE_BIT                 0
`define ST_IDLE                5'h01
`define ST_OUT_WAIT            5'h02
`define ST_CH_WAIT             5'h04
`define ST_CONV                5'h08
`define ST_NEXT                5'h10
`endif

// ===== logic/scan_map_check.v
// per-channel map checks and scan position lookup
`timescale 1ns/1ns
`include "scan_cfg_defs.vh"
module scan_map_check #(
  parameter NCH = 6
) (
  input  wire [8*NCH-1:0] i_maps,     // all channel fields, channel 0 lowest
  input  wire [2:0]       i_pos,      // scan position being looked up
  output wire             o_ord_err,  // enabled channel with bad position
  output wire             o_map_err,  // two outputs share a pin
  output reg              o_hit,      // an enabled channel holds i_pos
  output reg  [2:0]       o_hit_ch    // lowest such channel
);
  wire [NCH-1:0] ord_bad;
  wire [NCH-1:0] pos_match;
  wire [NCH-1:0] clash;
  genvar c, k;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      wire [7:0] f = i_maps[`CH_FIELD_W*c +: `CH_FIELD_W];
      wire [2:0] p = f[`POS_MSB:`POS_LSB];
      assign ord_bad[c]   = f[`EN_BIT] & ((p == 3'h0) | (p == 3'h7));
      assign pos_match[c] = f[`EN_BIT] & (p == i_pos);
      wire [NCH-1:0] same;
      for (k = 0; k < NCH; k = k + 1) begin : g_pair
        wire [7:0] g = i_maps[`CH_FIELD_W*k +: `CH_FIELD_W];
        assign same[k] = (k > c) & f[`OE_BIT] & g[`OE_BIT]
                         & (f[`MAP_MSB:`MAP_LSB] == g[`MAP_MSB:`MAP_LSB]);
      end
      assign clash[c] = |same;
    end
  endgenerate
  assign o_ord_err = |ord_bad;
  assign o_map_err = |clash;
  integer i;
  always @* begin
    o_hit    = 1'b0;
    o_hit_ch = 3'h0;
    for (i = NCH - 1; i >= 0; i = i - 1) begin
      if (pos_match[i]) begin
        o_hit    = 1'b1;
        o_hit_ch = i[2:0];
      end
    end
  end
endmodule

// ===== logic/scan_cfg.v
// scan sequencer configuration registers and channel stepping
//
// How it works
// - mode 1 converts only the channel in the select field, codes 0 to 5 being valid.
// - the mode field decodes 00, 01, 10, 11 as sequencer modes 1 to 4.
// - with the output delay enable set, channel selection waits the programmed output delay.
// - with the channel delay enable set, conversion start waits the programmed channel delay.
// - with ready inhibit set in mode 2, the ready low pulse only comes after the last channel.
// - the host sets the serial speed field to its bus rate and the block passes it on.
// - channel map writes are refused while a conversion is active.
// - each channel's output map picks which general output pin it activates.
// - the output map error is raised when two enabled outputs share one pin.
// - each channel's scan position, 1 to 6, sets its place in the scan.
// - the scan order error is raised for an enabled channel at position 000 or 111.
// - a channel's scan enable includes it in the scan or leaves it out.
// - a channel's output enable lets its mapped pin be driven while it is selected.
`timescale 1ns/1ns
`include "scan_cfg_defs.vh"
module scan_cfg #(
  parameter NCH = 6
) (
  input  wire        i_clk,                  // 100 MHz clock
  input  wire        i_rst_n,                // synchronous reset, active low
  input  wire        i_wr_en,                // register write strobe
  input  wire [2:0]  i_wr_addr,              // register write offset
  input  wire [23:0] i_wr_data,              // register write data
  input  wire        i_rd_en,                // register read strobe
  input  wire [2:0]  i_rd_addr,              // register read offset
  input  wire [7:0]  i_output_delay,         // output switch delay, cycles
  input  wire [7:0]  i_channel_delay,        // channel switch delay, cycles
  input  wire        i_start,                // start a scan pulse
  input  wire        i_conv_done,            // converter finished a channel
  output reg  [23:0] o_rd_data,              // register read data
  output reg         o_rd_valid,             // read data valid pulse
  output reg         o_wr_rejected,          // map write refused pulse
  output reg         o_busy,                 // conversion active
  output reg         o_conv_start,           // start conversion pulse
  output reg  [2:0]  o_conv_channel,         // channel being converted
  output reg  [NCH-1:0] o_general_output_pin, // general output pins
  output reg         o_conversion_ready_n,   // ready, active-low pulse
  output reg  [1:0]  o_serial_speed_range,   // serial clock speed range
  output reg  [1:0]  o_mode,                 // decoded sequencer mode
  output reg         o_output_map_error,     // pin shared by outputs
  output reg         o_scan_order_error      // bad enabled position
);
  reg  [15:0] scan_control_q;
  reg  [23:0] channel_map_high_q;
  reg  [23:0] channel_map_low_q;
  reg  [4:0]  state_q;
  reg  [2:0]  pos_q;
  reg  [2:0]  ch_q;
  reg  [7:0]  cnt_q;
  reg         single_q;

  wire        ord_err;
  wire        map_err;
  wire        hit;
  wire [2:0]  hit_ch;
  wire [47:0] maps = {channel_map_high_q, channel_map_low_q};
  wire [1:0]  mode = scan_control_q[`MODE_MSB:`MODE_LSB];
  wire [2:0]  sel  = scan_control_q[`SEL_MSB:`SEL_LSB];
  wire [7:0]  ch_field = maps[`CH_FIELD_W*ch_q +: `CH_FIELD_W];
  wire [2:0]  pin_idx  = ch_field[`MAP_MSB:`MAP_LSB];
  wire        inhibit  = scan_control_q[`RDY_INH_BIT] & (mode == `MODE_INHIBIT_OK);

  // last step once no enabled channel waits at a later valid position
  reg         more;
  integer     j;
  always @* begin
    more = 1'b0;
    for (j = 0; j < NCH; j = j + 1) begin
      if (maps[`CH_FIELD_W*j + `EN_BIT]
          && (maps[`CH_FIELD_W*j + `POS_LSB +: 3] > pos_q)
          && (maps[`CH_FIELD_W*j + `POS_LSB +: 3] <= `LAST_POSITION)) begin
        more = 1'b1;
      end
    end
  end
  wire        last_step = single_q | !more;

  scan_map_check #(
    .NCH (NCH)
  ) u_check (
    .i_maps    (maps),
    .i_pos     (pos_q),
    .o_ord_err (ord_err),
    .o_map_err (map_err),
    .o_hit     (hit),
    .o_hit_ch  (hit_ch)
  );

  wire map_wr = i_wr_en & ((i_wr_addr == `ADDR_CHANNEL_MAP_HIGH)
                         | (i_wr_addr == `ADDR_CHANNEL_MAP_LOW));

  // register writes
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      scan_control_q     <= `SCAN_CONTROL_RESET;
      channel_map_high_q <= `CHANNEL_MAP_RESET;
      channel_map_low_q  <= `CHANNEL_MAP_RESET;
      o_wr_rejected      <= 1'b0;
    end else begin
      o_wr_rejected <= map_wr & o_busy;
      if (i_wr_en && i_wr_addr == `ADDR_SCAN_CONTROL)
        scan_control_q <= i_wr_data[15:0] & `SCAN_CONTROL_WMASK;
      if (i_wr_en && !o_busy && i_wr_addr == `ADDR_CHANNEL_MAP_HIGH)
        channel_map_high_q <= i_wr_data;
      if (i_wr_en && !o_busy && i_wr_addr == `ADDR_CHANNEL_MAP_LOW)
        channel_map_low_q <= i_wr_data;
    end
  end

  // register reads and status outputs
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rd_data            <= 24'h000000;
      o_rd_valid           <= 1'b0;
      o_serial_speed_range <= 2'h0;
      o_mode               <= 2'h0;
      o_output_map_error   <= 1'b0;
      o_scan_order_error   <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      case (i_rd_addr)
        `ADDR_SCAN_CONTROL:     o_rd_data <= {8'h00, scan_control_q};
        `ADDR_CHANNEL_MAP_HIGH: o_rd_data <= channel_map_high_q;
        `ADDR_CHANNEL_MAP_LOW:  o_rd_data <= channel_map_low_q;
        default:                o_rd_data <= 24'h000000;
      endcase
      o_serial_speed_range <= scan_control_q[`SPEED_MSB:`SPEED_LSB];
      o_mode               <= mode;
      o_output_map_error   <= map_err;
      o_scan_order_error   <= ord_err;
    end
  end

  // channel stepping
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q              <= `ST_IDLE;
      pos_q                <= `FIRST_POSITION;
      ch_q                 <= 3'h0;
      cnt_q                <= 8'h00;
      single_q             <= 1'b0;
      o_busy               <= 1'b0;
      o_conv_start         <= 1'b0;
      o_conv_channel       <= 3'h0;
      o_general_output_pin <= {NCH{1'b0}};
      o_conversion_ready_n <= 1'b1;
    end else begin
      o_conv_start         <= 1'b0;
      o_conversion_ready_n <= 1'b1;
      case (state_q)
        `ST_IDLE: begin
          o_general_output_pin <= {NCH{1'b0}};
          if (i_start) begin
            if (mode == `MODE_SINGLE) begin
              if (sel <= `LAST_CHANNEL) begin
                single_q <= 1'b1;
                ch_q     <= sel;
                o_busy   <= 1'b1;
                cnt_q    <= 8'h00;
                state_q  <= `ST_OUT_WAIT;
              end
            end else begin
              single_q <= 1'b0;
              pos_q    <= `FIRST_POSITION;
              o_busy   <= 1'b1;
              state_q  <= `ST_NEXT;
            end
          end
        end
        `ST_NEXT: begin
          if (hit) begin
            ch_q    <= hit_ch;
            cnt_q   <= 8'h00;
            state_q <= `ST_OUT_WAIT;
          end else if (pos_q == `LAST_POSITION) begin
            o_busy  <= 1'b0;
            state_q <= `ST_IDLE;
          end else begin
            pos_q <= pos_q + 3'h1;
          end
        end
        `ST_OUT_WAIT: begin
          if (scan_control_q[`OUT_DLY_EN_BIT] && cnt_q < i_output_delay) begin
            cnt_q <= cnt_q + 8'h01;
          end else begin
            o_general_output_pin <= {NCH{1'b0}};
            if (ch_field[`OE_BIT] && pin_idx < NCH)
              o_general_output_pin[pin_idx] <= 1'b1;
            o_conv_channel <= ch_q;
            cnt_q          <= 8'h00;
            state_q        <= `ST_CH_WAIT;
          end
        end
        `ST_CH_WAIT: begin
          if (scan_control_q[`CH_DLY_EN_BIT] && cnt_q < i_channel_delay) begin
            cnt_q <= cnt_q + 8'h01;
          end else begin
            o_conv_start <= 1'b1;
            state_q      <= `ST_CONV;
          end
        end
        `ST_CONV: begin
          if (i_conv_done) begin
            if (!inhibit || last_step)
              o_conversion_ready_n <= 1'b0;
            if (last_step) begin
              o_busy  <= 1'b0;
              state_q <= `ST_IDLE;
            end else begin
              pos_q   <= pos_q + 3'h1;
              state_q <= `ST_NEXT;
            end
          end
        end
        default: state_q <= `ST_IDLE;
      endcase
    end
  end
endmodule

// ===== sim/scan_cfg_checker.sv
// port assertions for the scan configuration block
`timescale 1ns/1ns
module scan_cfg_checker #(
  parameter NCH = 6
) (
  input wire           i_clk,
  input wire           i_rst_n,
  input wire           i_wr_en,
  input wire [2:0]     i_wr_addr,
  input wire [23:0]    i_wr_data,
  input wire           i_start,
  input wire           i_conv_done,
  input wire           o_wr_rejected,
  input wire           o_busy,
  input wire           o_conv_start,
  input wire [2:0]     o_conv_channel,
  input wire [NCH-1:0] o_general_output_pin,
  input wire           o_conversion_ready_n,
  input wire [1:0]     o_mode
);
  reg  [15:0] sc_q;
  wire        sc_wr  = i_wr_en && i_wr_addr == 3'h4;
  wire        map_wr = i_wr_en && (i_wr_addr == 3'h5 || i_wr_addr == 3'h6);
  // shadow of the scan control word
  always @(posedge i_clk) begin
    if (!i_rst_n) sc_q <= 16'h0001;
    else if (sc_wr) sc_q <= i_wr_data[15:0] & 16'hff03;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_rej; map_wr && o_busy |=> o_wr_rejected; endproperty
  a_rej: assert property (p_rej) else $error("busy map write not refused");
  property p_acc; map_wr && !o_busy |=> !o_wr_rejected; endproperty
  a_acc: assert property (p_acc) else $error("idle map write refused");
  property p_mode; sc_wr ##1 !sc_wr |=> o_mode == $past(i_wr_data[12:11], 2); endproperty
  a_mode: assert property (p_mode) else $error("mode not decoded");
  property p_sel; o_conv_start && sc_q[12:11] == 2'h0 |-> o_conv_channel == sc_q[15:13];
  endproperty
  a_sel: assert property (p_sel) else $error("wrong single channel");
  property p_bad; i_start && !o_busy && sc_q[12:11] == 2'h0 && sc_q[15:13] > 3'h5
    |=> !o_busy; endproperty
  a_bad: assert property (p_bad) else $error("invalid channel started");
  property p_pin; $onehot0(o_general_output_pin); endproperty
  a_pin: assert property (p_pin) else $error("several output pins active");
  property p_rdy; $fell(o_conversion_ready_n) |-> $past(i_conv_done); endproperty
  a_rdy: assert property (p_rdy) else $error("ready without conversion");
  property p_nodly; $rose(o_busy) && sc_q[12:9] == 4'h0 |-> !o_conv_start ##2 o_conv_start;
  endproperty
  a_nodly: assert property (p_nodly) else $error("undelayed start late");
endmodule
bind scan_cfg scan_cfg_checker #(.NCH(NCH)) u_chk (.i_clk, .i_rst_n, .i_wr_en, .i_wr_addr,
  .i_wr_data, .i_start, .i_conv_done, .o_wr_rejected, .o_busy, .o_conv_start,
  .o_conv_channel, .o_general_output_pin, .o_conversion_ready_n, .o_mode);

// ===== sim/conv_model.sv
// converter model finishing each conversion after a set latency
`timescale 1ns/1ns
module conv_model (
  input  wire       i_clk,        // clock
  input  wire       i_rst_n,      // reset, active low
  input  wire       i_conv_start, // start pulse
  input  wire [3:0] i_lat,        // cycles to finish, 1 or more
  output reg        o_conv_done   // finished pulse
);
  reg [3:0] cnt_q;
  always @(posedge i_clk) begin
    o_conv_done <= 1'b0;
    if (!i_rst_n) cnt_q <= 4'h0;
    else if (i_conv_start) cnt_q <= i_lat;
    else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      o_conv_done <= cnt_q == 4'h1;
    end
  end
endmodule

// ===== sim/scan_cfg_tb.sv
// self-checking bench for the scan configuration block
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("FAIL %0t got %h exp %h", $time, a, b); end end
module scan_cfg_tb;
  reg         i_clk = 0, i_rst_n = 0, i_wr_en = 0, i_rd_en = 0, i_start = 0;
  reg  [2:0]  i_wr_addr = 0, i_rd_addr = 0;
  reg  [23:0] i_wr_data = 0, lo, hi;
  reg  [7:0]  i_output_delay = 0, i_channel_delay = 0;
  reg  [3:0]  lat = 1;
  reg  [31:0] seed = 32'h824c0c1a;
  wire [23:0] o_rd_data;
  wire [5:0]  o_general_output_pin;
  wire [2:0]  o_conv_channel;
  wire [1:0]  o_serial_speed_range, o_mode;
  wire        i_conv_done, o_rd_valid, o_wr_rejected, o_busy, o_conv_start;
  wire        o_conversion_ready_n, o_output_map_error, o_scan_order_error;
  integer     errors = 0, checks = 0, cyc = 0, n = 0, rdy = 0, rej = 0, t0, t1, base, i;
  reg  [2:0]  chs [0:7];
  reg  [5:0]  pins [0:7];
  scan_cfg #(.NCH(6)) dut (.i_clk, .i_rst_n, .i_wr_en, .i_wr_addr, .i_wr_data, .i_rd_en,
    .i_rd_addr, .i_output_delay, .i_channel_delay, .i_start, .i_conv_done, .o_rd_data,
    .o_rd_valid, .o_wr_rejected, .o_busy, .o_conv_start, .o_conv_channel,
    .o_general_output_pin, .o_conversion_ready_n, .o_serial_speed_range, .o_mode,
    .o_output_map_error, .o_scan_order_error);
  conv_model u_conv (.i_clk, .i_rst_n, .i_conv_start(o_conv_start), .i_lat(lat),
    .o_conv_done(i_conv_done));
  initial forever #5 i_clk = ~i_clk;
  // records every conversion start and ready pulse
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (!o_conversion_ready_n) rdy <= rdy + 1;
    if (o_wr_rejected) rej <= rej + 1;
    if (o_conv_start) begin
      if (n == 0) t1 <= cyc;
      chs[n[2:0]] <= o_conv_channel;
      pins[n[2:0]] <= o_general_output_pin;
      n <= n + 1;
    end
  end
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // expected {map error, order error} for six channel fields
  function [1:0] errs(input [47:0] m);
    integer a, b;
    begin
      errs = 0;
      for (a = 0; a < 6; a++) begin
        if (m[8*a+1] && m[8*a+2+:3] inside {3'h0, 3'h7}) errs[0] = 1;
        for (b = a + 1; b < 6; b++)
          if (m[8*a] && m[8*b] && m[8*a+5+:3] == m[8*b+5+:3]) errs[1] = 1;
      end
    end
  endfunction
  task wr(input [2:0] a, input [23:0] d);
    begin
      i_wr_en <= 1'b1;
      i_wr_addr <= a;
      i_wr_data <= d;
      @(posedge i_clk);
      i_wr_en <= 1'b0;
      @(posedge i_clk);
    end
  endtask
  task rd(input [2:0] a, input [23:0] e);
    begin
      i_rd_en <= 1'b1;
      i_rd_addr <= a;
      @(posedge i_clk);
      i_rd_en <= 1'b0;
      @(negedge i_clk);
      `CHK({o_rd_valid, o_rd_data}, {1'b1, e})
      @(posedge i_clk);
    end
  endtask
  // starts a scan, tries a map write two cycles later, waits for idle
  task scan;
    integer k;
    begin
      n = 0;
      rdy = 0;
      rej = 0;
      i_start <= 1'b1;
      @(posedge i_clk);
      i_start <= 1'b0;
      t0 = cyc;
      for (k = 0; (o_busy !== 1'b0 || k < 3) && k < 3000; k++) begin
        if (k == 2) wr(3'h6, 24'h0);
        @(posedge i_clk);
      end
      if (k >= 3000) errors++;
      repeat (3) @(posedge i_clk);
    end
  endtask
  task multi(input [1:0] m, input [5:0] en, input [5:0] oe, input inh);
    integer c, j;
    begin
      {hi, lo} = 0;
      for (c = 0; c < 6; c++) {hi, lo} = {hi, lo} | (48'({c[2:0], 3'(6 - c), en[c], oe[c]}) << 8 * c);
      wr(3'h5, hi);
      wr(3'h6, lo);
      wr(3'h4, {11'h0, m, 2'b00, inh, 8'h01});
      scan;
      rd(3'h6, lo);
      j = 0;
      for (c = 5; c >= 0; c--) if (en[c]) begin
        `CHK(chs[j], c[2:0])
        `CHK(pins[j], oe[c] ? 6'(1 << c) : 6'h0)
        j++;
      end
      `CHK(n, j)
      `CHK(rdy, (inh && m == 2'h1) ? 1 : j)
      `CHK(rej, 1)
    end
  endtask
  task print_verdict;
    begin
      if (errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rd(3'h4, 24'h000001);
    rd(3'h5, 24'h0);
    rd(3'h7, 24'h0);
    wr(3'h4, 24'hffffff);
    rd(3'h4, 24'h00ff03);
    for (i = 0; i < 4; i++) begin
      wr(3'h4, {11'h0, i[1:0], 9'h0, i[1:0]});
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      `CHK({o_mode, o_serial_speed_range}, {i[1:0], i[1:0]})
      @(posedge i_clk);
    end
    for (i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      lo = seed[23:0];
      seed = lfsr(seed);
      hi = seed[23:0];
      if (i == 0) {hi, lo} = 48'h2;
      if (i == 1) {hi, lo} = 48'h1e;
      wr(3'h5, hi);
      wr(3'h6, lo);
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      `CHK({o_output_map_error, o_scan_order_error}, errs({hi, lo}))
      @(posedge i_clk);
      rd(3'h5, hi);
    end
    multi(2'h1, 6'h3f, 6'h3f, 1'b1);
    multi(2'h2, 6'h3b, 6'h3d, 1'b0);
    multi(2'h3, 6'h3f, 6'h3f, 1'b1);
    wr(3'h4, 24'h000001);
    scan;
    base = t1 - t0;
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      i_output_delay <= {4'h0, seed[3:0]};
      i_channel_delay <= {4'h0, seed[7:4]};
      lat <= {1'b0, seed[10:8]} + 4'h1;
      wr(3'h4, {8'h0, i[2:0], 2'b00, seed[12:11], 9'h001});
      scan;
      `CHK(chs[0], i[2:0])
      `CHK(rej, 1)
      `CHK(t1 - t0, base + (seed[12] ? seed[3:0] : 0) + (seed[11] ? seed[7:4] : 0))
    end
    wr(3'h4, 24'h00e001);
    scan;
    `CHK(n, 0)
    `CHK(rej, 0)
    print_verdict;
  end
endmodule
